// ### rtl/ltmc_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module ltmc_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic flush_i,
  // fill and drain sides
  ltmc_stream_if.consumer wr_s,
  ltmc_stream_if.producer rd_s
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign wr_s.ready = (count_reg != (AW+1)'(DEPTH)) && !flush_i;
  assign rd_s.valid = (count_reg != '0) && !flush_i;
  assign rd_s.data  = mem_reg[rd_ptr_reg];
  assign push       = wr_s.valid && wr_s.ready;
  assign pop        = rd_s.valid && rd_s.ready;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= wr_s.data;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (flush_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule : ltmc_fifo

// ### rtl/ltmc_pkg.sv
// shared constants and types for the transceiver mode controller
package ltmc_pkg;

  // clock and bit rate
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned CLK_PERIOD_PS  = 5_000;
  localparam int unsigned BAUD_MAX       = 20_000;
  localparam int unsigned BIT_CYCLES     = CLK_HZ / BAUD_MAX;

  // wake-up and bus glitch filter lengths, in cycles
  localparam int unsigned LIN_FILT_CYCLES = 32;
  localparam int unsigned WUP_FILT_CYCLES = 32;

  // transmit buffer
  localparam int unsigned FIFO_WIDTH     = 1;
  localparam int unsigned FIFO_DEPTH     = 16;

  // filter channel positions
  localparam int unsigned CH_LIN         = 0;
  localparam int unsigned CH_WUP         = 1;
  localparam int unsigned CH_COUNT       = 2;

  // values after reset
  localparam logic        TX_BIT_RESET   = 1'b1;
  localparam logic        RXD_RESET      = 1'b1;
  localparam logic        INH_RESET      = 1'b1;
  localparam logic        DRV_EN_RESET   = 1'b1;

  // pull source defaults for undriven inputs
  localparam logic        TXD_PULL       = 1'b1;
  localparam logic        EN_PULL        = 1'b0;

  typedef enum logic [3:0] {
    MODE_STANDBY = 4'h1,
    MODE_NORMAL  = 4'h2,
    MODE_SLEEP   = 4'h4,
    MODE_SHORT   = 4'h8
  } ltmc_mode_type;

endpackage : ltmc_pkg

// ### rtl/ltmc_stream_if.sv
// valid/ready stream carrier between the controller and its buffer
`timescale 1ns/1ps
interface ltmc_stream_if #(
  parameter int unsigned WIDTH = 1
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport producer (output valid, output data, input ready);
  modport consumer (input valid, input data, output ready);
endinterface : ltmc_stream_if

// ### rtl/ltmc_top.sv
// single-wire bus transceiver mode controller with buffered transmit path
`timescale 1ns/1ps

//
// Contract
// RULE_01 - normal mode, control low, no wake pending: go to sleep
// RULE_02 - short mode goes to sleep once bus short is gone
// RULE_03 - entering sleep drops regulator inhibit output low
// RULE_04 - sleep ignores transmit input, never drives bus dominant
// RULE_05 - sleep: bus dominant or local wake edge goes to standby
// RULE_06 - bus and local wake inputs are glitch filtered
// RULE_07 - control input high wakes from sleep as valid wake-up
// RULE_08 - every valid wake-up raises regulator inhibit output high
// RULE_09 - bus wake-up drives receive output dominant low as interrupt
// RULE_10 - control low on shorted bus holds short mode until recessive
// RULE_11 - undriven transmit and control inputs default to recessive-safe levels
// RULE_12 - over-temperature disables driver until cooled flag clears
// RULE_13 - after reset the controller starts in standby
// RULE_14 - standby passes bus to receive output, blocks transmit
// RULE_15 - normal entered only from standby or sleep with control high
// RULE_16 - short mode: receive hi-z, inhibit low, transmit ignored
// RULE_17 - filter lengths are cycle-count parameters
// RULE_18 - normal: low transmit drives bus dominant, receive mirrors bus
module ltmc_top #(
  parameter int unsigned BIT_CYCLES      = ltmc_pkg::BIT_CYCLES,
  parameter int unsigned LIN_FILT_CYCLES = ltmc_pkg::LIN_FILT_CYCLES,
  parameter int unsigned WUP_FILT_CYCLES = ltmc_pkg::WUP_FILT_CYCLES,
  parameter int unsigned FIFO_WIDTH      = ltmc_pkg::FIFO_WIDTH,
  parameter int unsigned FIFO_DEPTH      = ltmc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // controller side
  input  wire logic txd_i,
  input  wire logic txd_driven_i,
  input  wire logic mode_en_i,
  input  wire logic mode_en_driven_i,
  output logic      tx_ready_o,
  output logic      rxd_o,
  output logic      rxd_oe_o,
  // local wake and regulator
  input  wire logic local_wake_input_i,
  output logic      regulator_inhibit_out_o,
  // thermal sensor
  input  wire logic overtemp_i,
  // bus pin, open drain
  input  wire logic lin_i,
  output logic      lin_o,
  output logic      lin_oe_o,
  // status
  output logic [3:0] mode_o,
  output logic      remote_wake_o
);
  localparam int unsigned BW = (BIT_CYCLES > 1) ? $clog2(BIT_CYCLES) : 1;
  localparam int unsigned FW =
    $clog2(((LIN_FILT_CYCLES > WUP_FILT_CYCLES) ? LIN_FILT_CYCLES : WUP_FILT_CYCLES) + 1);

  ltmc_pkg::ltmc_mode_type mode_reg;
  ltmc_pkg::ltmc_mode_type mode_next;

  logic                txd_eff;
  logic                en_eff;
  logic [BW-1:0]       bit_cnt_reg;
  logic                bit_tick;
  logic [ltmc_pkg::CH_COUNT-1:0] filt_raw;
  logic [ltmc_pkg::CH_COUNT-1:0] filt_reg;
  logic                seeded_reg;
  logic                wup_prev_reg;
  logic                lin_dom;
  logic                wup_edge;
  logic                remote_wake_reg;
  logic                drv_en_reg;
  logic                tx_bit_reg;
  logic                rxd_reg;
  logic                rxd_oe_reg;
  logic                inh_reg;
  logic                lin_oe_reg;
  logic                tx_active;

  ltmc_stream_if #(.WIDTH(FIFO_WIDTH)) wr_s ();
  ltmc_stream_if #(.WIDTH(FIFO_WIDTH)) rd_s ();

  // pull sources for undriven pins
  assign txd_eff = txd_driven_i ? txd_i : ltmc_pkg::TXD_PULL;         // RULE_11
  assign en_eff  = mode_en_driven_i ? mode_en_i : ltmc_pkg::EN_PULL;  // RULE_11

  // bit-rate enable
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_reg <= '0;
    end else if (bit_cnt_reg == BW'(BIT_CYCLES - 1)) begin
      bit_cnt_reg <= '0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
    end
  end

  assign bit_tick = (bit_cnt_reg == BW'(BIT_CYCLES - 1));

  // glitch filters: level must hold for the full count
  assign filt_raw[ltmc_pkg::CH_LIN] = ~lin_i;
  assign filt_raw[ltmc_pkg::CH_WUP] = local_wake_input_i;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seeded_reg <= 1'b0;
    end else begin
      seeded_reg <= 1'b1;
    end
  end

  for (genvar ch = 0; ch < ltmc_pkg::CH_COUNT; ch++) begin : g_filt
    localparam int unsigned LEN =
      (ch == ltmc_pkg::CH_LIN) ? LIN_FILT_CYCLES : WUP_FILT_CYCLES;
    logic [FW-1:0] cnt_reg;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cnt_reg     <= '0;
        filt_reg[ch] <= 1'b0;
      end else if (!seeded_reg) begin
        cnt_reg     <= '0;
        filt_reg[ch] <= filt_raw[ch];
      end else if (filt_raw[ch] == filt_reg[ch]) begin
        cnt_reg <= '0;                                                 // RULE_06
      end else if (cnt_reg >= FW'(LEN - 1)) begin
        cnt_reg     <= '0;
        filt_reg[ch] <= filt_raw[ch];                                  // RULE_17
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign lin_dom = filt_reg[ltmc_pkg::CH_LIN];

  // edge of filtered local wake level
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wup_prev_reg <= 1'b0;
    end else if (!seeded_reg) begin
      wup_prev_reg <= filt_raw[ltmc_pkg::CH_WUP];
    end else begin
      wup_prev_reg <= filt_reg[ltmc_pkg::CH_WUP];
    end
  end

  assign wup_edge = seeded_reg && (wup_prev_reg != filt_reg[ltmc_pkg::CH_WUP]); // RULE_05

  // mode sequencing
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      ltmc_pkg::MODE_STANDBY: begin
        if (en_eff) begin
          mode_next = ltmc_pkg::MODE_NORMAL;                           // RULE_15
        end
      end
      ltmc_pkg::MODE_NORMAL: begin
        if (!en_eff) begin
          if (lin_dom) begin
            mode_next = ltmc_pkg::MODE_SHORT;                          // RULE_10
          end else if (wup_edge) begin
            mode_next = ltmc_pkg::MODE_STANDBY;
          end else begin
            mode_next = ltmc_pkg::MODE_SLEEP;                          // RULE_01
          end
        end
      end
      ltmc_pkg::MODE_SLEEP: begin
        if (en_eff) begin
          mode_next = ltmc_pkg::MODE_NORMAL;                           // RULE_07
        end else if (lin_dom || wup_edge) begin
          mode_next = ltmc_pkg::MODE_STANDBY;                          // RULE_05
        end
      end
      ltmc_pkg::MODE_SHORT: begin
        if (!lin_dom) begin
          mode_next = ltmc_pkg::MODE_SLEEP;                            // RULE_02
        end
      end
      default: begin
        mode_next = ltmc_pkg::MODE_STANDBY;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= ltmc_pkg::MODE_STANDBY;                              // RULE_13
    end else begin
      mode_reg <= mode_next;
    end
  end

  // remote wake marker, held until normal mode is entered
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remote_wake_reg <= 1'b0;
    end else if (mode_reg == ltmc_pkg::MODE_SLEEP &&
                 mode_next == ltmc_pkg::MODE_STANDBY && lin_dom) begin
      remote_wake_reg <= 1'b1;                                         // RULE_09
    end else if (mode_next != ltmc_pkg::MODE_STANDBY) begin
      remote_wake_reg <= 1'b0;
    end
  end

  // regulator inhibit: high while awake
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inh_reg <= ltmc_pkg::INH_RESET;
    end else if (mode_next == ltmc_pkg::MODE_SLEEP ||
                 mode_next == ltmc_pkg::MODE_SHORT) begin
      inh_reg <= 1'b0;                                                 // RULE_03 RULE_16
    end else begin
      inh_reg <= 1'b1;                                                 // RULE_08
    end
  end

  // thermal shutdown of the driver stage
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drv_en_reg <= ltmc_pkg::DRV_EN_RESET;
    end else begin
      drv_en_reg <= !overtemp_i;                                       // RULE_12
    end
  end

  // transmit path: sample per bit into the buffer, drain to the bus
  assign tx_active  = (mode_reg == ltmc_pkg::MODE_NORMAL);
  assign wr_s.valid = tx_active && bit_tick;
  assign wr_s.data  = FIFO_WIDTH'(txd_eff);
  assign rd_s.ready = tx_active && drv_en_reg && bit_tick;             // RULE_12
  assign tx_ready_o = wr_s.ready && tx_active;

  ltmc_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .flush_i   (!tx_active),                                           // RULE_04 RULE_14
    .wr_s      (wr_s),
    .rd_s      (rd_s)
  );

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_bit_reg <= ltmc_pkg::TX_BIT_RESET;
    end else if (!tx_active) begin
      tx_bit_reg <= 1'b1;                                              // RULE_16
    end else if (rd_s.valid && rd_s.ready) begin
      tx_bit_reg <= rd_s.data[0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lin_oe_reg <= 1'b0;
    end else begin
      lin_oe_reg <= tx_active && (mode_next == ltmc_pkg::MODE_NORMAL) &&
                    drv_en_reg && !tx_bit_reg;                         // RULE_18 RULE_04
    end
  end

  // receive output
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rxd_reg    <= ltmc_pkg::RXD_RESET;
      rxd_oe_reg <= 1'b1;
    end else begin
      case (mode_reg)
        ltmc_pkg::MODE_NORMAL: begin
          rxd_reg    <= lin_i;                                         // RULE_18
          rxd_oe_reg <= 1'b1;
        end
        ltmc_pkg::MODE_STANDBY: begin
          rxd_reg    <= remote_wake_reg ? 1'b0 : lin_i;                // RULE_09 RULE_14
          rxd_oe_reg <= 1'b1;
        end
        ltmc_pkg::MODE_SHORT: begin
          rxd_reg    <= 1'b1;
          rxd_oe_reg <= 1'b0;                                          // RULE_16
        end
        default: begin
          rxd_reg    <= 1'b1;
          rxd_oe_reg <= 1'b1;
        end
      endcase
    end
  end

  assign rxd_o                   = rxd_reg;
  assign rxd_oe_o                = rxd_oe_reg;
  assign regulator_inhibit_out_o = inh_reg;
  assign lin_o                   = 1'b0;
  assign lin_oe_o                = lin_oe_reg;
  assign mode_o                  = mode_reg;
  assign remote_wake_o           = remote_wake_reg;

endmodule : ltmc_top

// ### sim/ltmc_bus_model.sv
// bus network model: pull-up to recessive, any driver wins dominant
`timescale 1ns/1ps
module ltmc_bus_model (
  // drivers
  input  wire logic lin_oe_i,
  input  wire logic short_i,
  // bus level
  output logic      lin_o
);
  // released bus returns to recessive through the pull-up
  assign lin_o = ~(lin_oe_i | short_i);
endmodule : ltmc_bus_model

// ### sim/ltmc_top_asserts.sv
// concurrent checks on the mode controller's ports
`timescale 1ns/1ps
module ltmc_top_asserts #(
  parameter int unsigned LIN_FILT_CYCLES = ltmc_pkg::LIN_FILT_CYCLES
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  // watched inputs
  input  wire logic       mode_en_i,
  input  wire logic       mode_en_driven_i,
  input  wire logic       overtemp_i,
  input  wire logic       lin_i,
  // watched outputs
  input  wire logic       tx_ready_o,
  input  wire logic       rxd_o,
  input  wire logic       rxd_oe_o,
  input  wire logic       regulator_inhibit_out_o,
  input  wire logic       lin_oe_o,
  input  wire logic [3:0] mode_o,
  input  wire logic       remote_wake_o
);
  logic        en_eff;
  logic [15:0] low_cnt_reg;
  assign en_eff = mode_en_i & mode_en_driven_i;
  // consecutive dominant cycles seen on the bus
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) low_cnt_reg <= 16'h0000;
    else if (lin_i) low_cnt_reg <= 16'h0000;
    else if (low_cnt_reg != 16'hFFFF) low_cnt_reg <= low_cnt_reg + 16'h0001;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_sleep_no_drive: assert property (mode_o == 4'h4 && $past(mode_o) == 4'h4 |-> !lin_oe_o)
    else $error("bus driven in sleep");
  a_sleep_inh_low: assert property (mode_o == 4'h4 |-> !regulator_inhibit_out_o)
    else $error("inhibit high in sleep");
  a_awake_inh_high: assert property (mode_o inside {4'h1, 4'h2} |-> regulator_inhibit_out_o)
    else $error("inhibit low while awake");
  a_short_outputs: assert property (mode_o == 4'h8 && $past(mode_o) == 4'h8 |-> !rxd_oe_o && !regulator_inhibit_out_o)
    else $error("short mode outputs wrong");
  a_normal_entry: assert property (mode_o == 4'h2 && $past(mode_o) != 4'h2 |-> $past(en_eff) && $past(mode_o) != 4'h8)
    else $error("bad entry to normal");
  a_short_entry: assert property (mode_o == 4'h8 && $past(mode_o) != 4'h8 |-> $past(mode_o) == 4'h2 && !$past(en_eff))
    else $error("bad entry to short");
  a_short_hold: assert property (mode_o == 4'h8 && !lin_i |=> mode_o == 4'h8)
    else $error("short left while bus dominant");
  a_sleep_entry: assert property (mode_o == 4'h4 && $past(mode_o) != 4'h4 |-> ($past(mode_o) == 4'h2 && !$past(en_eff)) || $past(mode_o) == 4'h8)
    else $error("bad entry to sleep");
  a_bus_wake_filter: assert property ($rose(remote_wake_o) |-> low_cnt_reg >= LIN_FILT_CYCLES && $past(mode_o) == 4'h4)
    else $error("bus wake without filtered dominant");
  a_wake_rxd_low: assert property (remote_wake_o && $past(remote_wake_o) |-> !rxd_o)
    else $error("receive output not low after bus wake");
  a_overtemp_off: assert property (overtemp_i [*3] |-> !lin_oe_o)
    else $error("driver on while hot");
  a_rx_mirror: assert property (mode_o == 4'h2 && $past(mode_o) == 4'h2 |-> rxd_o == $past(lin_i))
    else $error("receive output not mirroring bus");
  a_ready_normal: assert property (tx_ready_o |-> mode_o == 4'h2)
    else $error("transmit ready outside normal");
  c_short: cover property (mode_o == 4'h8);
  c_bus_wake: cover property ($rose(remote_wake_o));
  c_tx_dom: cover property (mode_o == 4'h2 && lin_oe_o);
endmodule : ltmc_top_asserts

// ### sim/testbench.sv
// self-checking bench for the transceiver mode controller
`timescale 1ns/1ps
module testbench;
  logic       ref_clk_i = 1'b0;
  logic       rst_n_i   = 1'b0;
  logic       txd       = 1'b1;
  logic       txd_drv   = 1'b1;
  logic       en        = 1'b0;
  logic       en_drv    = 1'b1;
  logic       local_wake_input       = 1'b0;
  logic       hot       = 1'b0;
  logic       shrt      = 1'b0;
  logic       rdy, rxd, rxd_oe, regulator_inhibit_out, lin, lin_o, lin_oe, rwake;
  logic [3:0] mode;
  int         fails     = 0;
  int         checks    = 0;

  ltmc_top #(.BIT_CYCLES(8), .LIN_FILT_CYCLES(4), .WUP_FILT_CYCLES(4)) DUT (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .txd_i(txd), .txd_driven_i(txd_drv),
    .mode_en_i(en), .mode_en_driven_i(en_drv), .tx_ready_o(rdy), .rxd_o(rxd),
    .rxd_oe_o(rxd_oe), .local_wake_input_i(local_wake_input), .regulator_inhibit_out_o(regulator_inhibit_out),
    .overtemp_i(hot), .lin_i(lin), .lin_o(lin_o), .lin_oe_o(lin_oe), .mode_o(mode),
    .remote_wake_o(rwake));
  ltmc_bus_model BUS (.lin_oe_i(lin_oe), .short_i(shrt), .lin_o(lin));

  initial forever #2.5 ref_clk_i = ~ref_clk_i;

  task automatic cy(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : cy
  task automatic chk_bit(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit
  task automatic chk_mode(input logic [3:0] e);
    checks++;
    if (mode !== e) begin
      fails++;
      $display("mismatch mode expected %h seen %h", e, mode);
    end
  endtask : chk_mode
  task automatic go(input logic [3:0] m, input int n);
    repeat (n) if (mode !== m) @(negedge ref_clk_i);
    chk_mode(m);
  endtask : go
  task automatic to_sleep;
    txd = 1'b1;
    en  = 1'b1;
    cy(200);
    en  = 1'b0;
    go(4'h4, 12);
  endtask : to_sleep
  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic t_normal;
    chk_mode(4'h1);
    chk_bit("lin_oe", 1'b0, lin_oe);
    chk_bit("tx_ready", 1'b0, rdy);
    chk_bit("rxd_oe", 1'b1, rxd_oe);
    en = 1'b1;
    go(4'h2, 4);
    chk_bit("tx_ready", 1'b1, rdy);
    chk_bit("lin_o", 1'b0, lin_o);
    txd = 1'b0;
    repeat (60) if (lin_oe !== 1'b1) @(negedge ref_clk_i);
    chk_bit("lin_oe", 1'b1, lin_oe);
    cy(2);
    chk_bit("rxd", 1'b0, rxd);
    hot = 1'b1;
    cy(4);
    chk_bit("lin_oe", 1'b0, lin_oe);
    cy(130);
    chk_bit("tx_ready", 1'b0, rdy);
    hot = 1'b0;
    cy(20);
    chk_bit("lin_oe", 1'b1, lin_oe);
  endtask : t_normal
  task automatic t_sleep;
    to_sleep();
    chk_bit("inhibit", 1'b0, regulator_inhibit_out);
    txd = 1'b0;
    cy(24);
    chk_bit("lin_oe", 1'b0, lin_oe);
    shrt = 1'b1;
    cy(2);
    shrt = 1'b0;
    local_wake_input = 1'b1;
    cy(2);
    local_wake_input = 1'b0;
    cy(10);
    chk_mode(4'h4);
  endtask : t_sleep
  task automatic t_bus_wake;
    shrt = 1'b1;
    go(4'h1, 12);
    chk_bit("inhibit", 1'b1, regulator_inhibit_out);
    chk_bit("remote_wake", 1'b1, rwake);
    cy(1);
    chk_bit("rxd", 1'b0, rxd);
    shrt = 1'b0;
    cy(8);
    chk_bit("lin_oe", 1'b0, lin_oe);
  endtask : t_bus_wake
  task automatic t_local_wake;
    to_sleep();
    local_wake_input = 1'b1;
    go(4'h1, 12);
    chk_bit("inhibit", 1'b1, regulator_inhibit_out);
    chk_bit("remote_wake", 1'b0, rwake);
  endtask : t_local_wake
  task automatic t_en_wake;
    to_sleep();
    en = 1'b1;
    go(4'h2, 4);
    chk_bit("inhibit", 1'b1, regulator_inhibit_out);
    en_drv = 1'b0;
    go(4'h4, 12);
    en_drv  = 1'b1;
    txd_drv = 1'b0;
    txd     = 1'b0;
    go(4'h2, 4);
    cy(40);
    chk_bit("lin_oe", 1'b0, lin_oe);
    txd_drv = 1'b1;
    txd     = 1'b1;
  endtask : t_en_wake
  task automatic t_short;
    shrt = 1'b1;
    cy(8);
    en = 1'b0;
    go(4'h8, 4);
    cy(1);
    chk_bit("rxd_oe", 1'b0, rxd_oe);
    chk_bit("inhibit", 1'b0, regulator_inhibit_out);
    txd = 1'b0;
    cy(24);
    chk_bit("lin_oe", 1'b0, lin_oe);
    chk_mode(4'h8);
    shrt = 1'b0;
    go(4'h4, 12);
  endtask : t_short

  initial begin
    cy(2);
    rst_n_i = 1'b1;
    cy(2);
    t_normal();
    t_sleep();
    t_bus_wake();
    t_local_wake();
    t_en_wake();
    t_short();
    close_out();
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    fails++;
    close_out();
  end
endmodule : testbench

bind ltmc_top ltmc_top_asserts #(.LIN_FILT_CYCLES(LIN_FILT_CYCLES)) CHK (
  .ref_clk_i, .rst_n_i, .mode_en_i, .mode_en_driven_i, .overtemp_i, .lin_i,
  .tx_ready_o, .rxd_o, .rxd_oe_o, .regulator_inhibit_out_o, .lin_oe_o, .mode_o,
  .remote_wake_o);
